// File: cfe_defines.svh
`ifndef CFE_DEFINES_SVH
`define CFE_DEFINES_SVH

// width of every line and pixel counter, covers 1023 lines by 1023 clocks
`define CFE_CNT_W        10
// highest value a capture counter reaches before it saturates
`define CFE_CNT_MAX      10'h3ff
// reset value of all counters
`define CFE_CNT_RST      10'h000
// default length of the generated horizontal sync pulse, in pixel clocks
`define CFE_HSYNC_WIDTH  64
// pins that pass the synchroniser: clock, qualifier, luma, chroma, hs, vs, field
`define CFE_PIN_W        21

`endif

// File: cfe_pkg.sv
`include "cfe_defines.svh"

package cfe_pkg;

    typedef logic [`CFE_CNT_W-1:0] cfe_cnt_t;

    // one captured 4:2:2 sample
    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
    } cfe_pixel_s;

    // active window of the incoming video
    typedef struct packed {
        cfe_cnt_t firstLineCount;
        cfe_cnt_t lastLineCount;
        cfe_cnt_t firstPixelCount;
        cfe_cnt_t lastPixelCount;
    } cfe_window_s;

    // timing of the generated syncs
    typedef struct packed {
        cfe_cnt_t linesPerFrameTotal;
        cfe_cnt_t clocksPerLineTotal;
        cfe_cnt_t vsyncPulseLines;
        cfe_cnt_t hsyncStart;
    } cfe_timing_s;

endpackage

// File: cfe_sync.sv
`timescale 1ns/1ns

module cfe_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin : gBadWidth
        $error("cfe_sync needs at least one bit");
    end

    // two flops per bit; stage1 feeds nothing but q
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stage1 <= '0;
            q      <= '0;
        end else if (ce) begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule

// File: cfe_capture_front_end.sv
// Contract
// R1 - capture bus on every other pixel clock rise
// R2 - qualifier polarity selects which rising edge captures
// R3 - field source: field pin or hsync/vsync relation
// R4 - top select sets field pin top level
// R5 - hsync level at vsync edge gives field
// R6 - lines counted from vsync edge, start to end
// R7 - pixels counted from hsync edge, start to end
// R8 - hsync edge select and generated hsync polarity
// R9 - vsync edge select and generated vsync polarity
// R10 - ten bit counters cover 1023 by 1023
// R11 - generator enable drives both syncs out
// R12 - generated frame holds frame total lines
// R13 - generated line lasts line total clocks
// R14 - vsync pulse lasts vsync size lines
// R15 - hsync asserts at hsync start position
// R16 - sync outputs change on qualified falling edges
// R17 - odd field vsync edges mid inactive hsync
// R18 - even field vsync edges mid active hsync
// R19 - only in-window samples forwarded with valid
`timescale 1ns/1ns
`include "cfe_defines.svh"

module cfe_capture_front_end #(
    parameter int HSYNC_WIDTH = `CFE_HSYNC_WIDTH
) (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                ce,
    input  wire logic                doubleRatePixelClock,
    input  wire logic                phaseQualifierClock,
    input  wire logic [7:0]          lumaIn,
    input  wire logic [7:0]          chromaIn,
    input  wire logic                hsyncIn,
    input  wire logic                vsyncIn,
    input  wire logic                fieldIdInput,
    input  wire logic                qualifierPolaritySel,
    input  wire logic                useExternalFieldSel,
    input  wire logic                topFieldLevelSel,
    input  wire logic                hsyncNegativeEdgeSel,
    input  wire logic                vsyncNegativeEdgeSel,
    input  wire logic                syncGeneratorEnable,
    input  wire cfe_pkg::cfe_window_s window,
    input  wire cfe_pkg::cfe_timing_s timing,
    output cfe_pkg::cfe_pixel_s      pixelOut,
    output logic                     pixelValid,
    output logic                     fieldTop,
    output cfe_pkg::cfe_cnt_t        lineCount,
    output cfe_pkg::cfe_cnt_t        pixelCount,
    output logic                     hsyncOut,
    output logic                     hsyncOe,
    output logic                     vsyncOut,
    output logic                     vsyncOe,
    output logic                     genFieldEven
);
    import cfe_pkg::*;

    localparam int W = `CFE_CNT_W;
    localparam int E = `CFE_CNT_W + 1;
    localparam logic [W-1:0] HSW = W'(HSYNC_WIDTH);
    localparam logic [W-1:0] CNT_MAX = `CFE_CNT_MAX;

    // the pulse must fit inside a line of the widest format
    if (HSYNC_WIDTH < 1 || HSYNC_WIDTH > 1022) begin : gBadHsw
        $error("HSYNC_WIDTH must lie between 1 and 1022");
    end

    // ------------------------------------------------------------------
    // pin synchronisation: every pin, the two video clocks included,
    // passes two flops so that all of them arrive with the same delay
    // ------------------------------------------------------------------
    logic [`CFE_PIN_W-1:0] pinRaw;
    logic [`CFE_PIN_W-1:0] pinSync;

    assign pinRaw = {doubleRatePixelClock, phaseQualifierClock, lumaIn, chromaIn,
                     hsyncIn, vsyncIn, fieldIdInput};

    cfe_sync #(
        .WIDTH (`CFE_PIN_W)
    ) uPinSync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .d       (pinRaw),
        .q       (pinSync)
    );

    wire       dblS    = pinSync[20];
    wire       qualS   = pinSync[19];
    wire [7:0] lumaS   = pinSync[18:11];
    wire [7:0] chromaS = pinSync[10:3];
    wire       hsS     = pinSync[2];
    wire       vsS     = pinSync[1];
    wire       fiS     = pinSync[0];

    // ------------------------------------------------------------------
    // edge finding on the sampled double-rate clock
    // ------------------------------------------------------------------
    logic dblPrev;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dblPrev <= 1'b0;
        end else if (ce) begin
            dblPrev <= dblS;
        end
    end

    wire dblRise    = dblS & ~dblPrev;
    wire dblFall    = ~dblS & dblPrev;
    // only one rise in two is used; the qualifier level picks it
    wire qualMatch  = (qualS == qualifierPolaritySel);   // [R2]
    wire sampleTick = dblRise & qualMatch;               // [R1]
    // the falling edge before a used rise sees the same qualifier level
    wire genTick    = dblFall & qualMatch;               // [R16]

    // ------------------------------------------------------------------
    // capture side: sync edges, counters, field and window
    // ------------------------------------------------------------------
    logic     hsPrev;
    logic     vsPrev;
    logic     internalTop;
    cfe_cnt_t capPix;
    cfe_cnt_t capLine;

    // active edge chosen by the edge selects
    wire hsEdge = hsyncNegativeEdgeSel ? (hsPrev & ~hsS) : (~hsPrev & hsS);  // [R8]
    wire vsEdge = vsyncNegativeEdgeSel ? (vsPrev & ~vsS) : (~vsPrev & vsS);  // [R9]

    // counts saturate so a missing sync cannot wrap back into the window
    wire [W-1:0] pixInc  = (capPix == CNT_MAX) ? CNT_MAX : capPix + W'(1);    // [R10]
    wire [W-1:0] lineInc = (capLine == CNT_MAX) ? CNT_MAX : capLine + W'(1);  // [R10]

    // counts that belong to the sample taken in this cycle
    wire [W-1:0] next_capPix  = hsEdge ? '0 : pixInc;                          // [R7]
    wire [W-1:0] next_capLine = vsEdge ? '0 : (hsEdge ? lineInc : capLine);    // [R6]

    // hsync level caught at the vsync edge names the field
    wire next_internalTop = vsEdge ? (hsS == topFieldLevelSel) : internalTop;   // [R5]
    wire externalTop      = (fiS == topFieldLevelSel);                          // [R4]
    wire curTop           = useExternalFieldSel ? externalTop : next_internalTop; // [R3]

    // window is inclusive at both ends
    wire lineInWin = (next_capLine >= window.firstLineCount) &&
                     (next_capLine <= window.lastLineCount);                    // [R6]
    wire pixInWin  = (next_capPix >= window.firstPixelCount) &&
                     (next_capPix <= window.lastPixelCount);                    // [R7]
    wire inWindow  = lineInWin & pixInWin;                                      // [R19]

    // capture state only moves on a qualified rise
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hsPrev      <= 1'b0;
            vsPrev      <= 1'b0;
            capPix      <= `CFE_CNT_RST;
            capLine     <= `CFE_CNT_RST;
            internalTop <= 1'b0;
        end else if (ce && sampleTick) begin
            hsPrev      <= hsS;
            vsPrev      <= vsS;
            capPix      <= next_capPix;
            capLine     <= next_capLine;
            internalTop <= next_internalTop;
        end
    end

    // outputs to the pipeline; valid is a one-cycle strobe per kept sample
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pixelOut   <= '0;
            pixelValid <= 1'b0;
            fieldTop   <= 1'b0;
            lineCount  <= `CFE_CNT_RST;
            pixelCount <= `CFE_CNT_RST;
        end else if (ce) begin
            pixelValid <= sampleTick & inWindow;   // [R19]
            if (sampleTick) begin
                pixelOut   <= '{luma: lumaS, chroma: chromaS};
                fieldTop   <= curTop;
                lineCount  <= next_capLine;
                pixelCount <= next_capPix;
            end
        end
    end

    // ------------------------------------------------------------------
    // sync generator
    // ------------------------------------------------------------------
    cfe_cnt_t genPix;
    cfe_cnt_t genLine;
    logic     hsAct;
    logic     vsAct;
    logic     evenField;

    wire [W-1:0] clocksTot = timing.clocksPerLineTotal;
    wire [W-1:0] linesTot  = timing.linesPerFrameTotal;
    wire [W-1:0] hsStart   = timing.hsyncStart;
    wire [W-1:0] vsLines   = timing.vsyncPulseLines;

    // wrap at total-1; a total of 0 or 1 pins the counter at 0
    wire pixWrap  = (E'(genPix) + E'(1)) >= E'(clocksTot);   // [R13]
    wire lineWrap = (E'(genLine) + E'(1)) >= E'(linesTot);   // [R12]

    wire [W-1:0] next_genPix  = pixWrap ? '0 : genPix + W'(1);                  // [R13]
    wire [W-1:0] next_genLine = pixWrap ? (lineWrap ? '0 : genLine + W'(1))
                                        : genLine;                              // [R12]

    // distance past the hsync start, taken modulo the line length
    wire [E-1:0] hsOffset = (next_genPix >= hsStart)
                          ? E'(next_genPix) - E'(hsStart)
                          : E'(next_genPix) + E'(clocksTot) - E'(hsStart);
    wire next_hsAct = hsOffset < E'(HSW);                                       // [R15]

    // middle of the inactive part: after the pulse plus half the remainder;
    // a line shorter than the pulse gives a meaningless position
    wire [E-1:0] midOddRaw  = E'(hsStart) + E'(HSW) + ((E'(clocksTot) - E'(HSW)) >> 1);
    wire [E-1:0] midEvenRaw = E'(hsStart) + E'(HSW >> 1);
    wire [W-1:0] midOdd  = (midOddRaw >= E'(clocksTot))
                         ? W'(midOddRaw - E'(clocksTot)) : W'(midOddRaw);       // [R17]
    wire [W-1:0] midEven = (midEvenRaw >= E'(clocksTot))
                         ? W'(midEvenRaw - E'(clocksTot)) : W'(midEvenRaw);     // [R18]

    // odd field starts on line 0, even field half a frame later
    wire [W-1:0] halfLine = linesTot >> 1;
    wire oddSet   = (next_genLine == '0) && (next_genPix == midOdd);            // [R17]
    wire oddClr   = (E'(next_genLine) == E'(vsLines)) &&
                    (next_genPix == midOdd);                                    // [R14]
    wire evenSet  = (next_genLine == halfLine) && (next_genPix == midEven);     // [R18]
    wire evenClr  = (E'(next_genLine) == E'(halfLine) + E'(vsLines)) &&
                    (next_genPix == midEven);                                   // [R14]

    // clear first, so a zero-line pulse size gives no pulse at all
    wire next_vsAct = (oddClr | evenClr) ? 1'b0
                    : ((oddSet | evenSet) ? 1'b1 : vsAct);                      // [R14]
    wire next_evenField = evenSet ? 1'b1 : (oddSet ? 1'b0 : evenField);

    // counters run only while the generator is enabled, and restart from 0
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            genPix    <= `CFE_CNT_RST;
            genLine   <= `CFE_CNT_RST;
            hsAct     <= 1'b0;
            vsAct     <= 1'b0;
            evenField <= 1'b0;
        end else if (ce) begin
            if (!syncGeneratorEnable) begin
                genPix    <= `CFE_CNT_RST;
                genLine   <= `CFE_CNT_RST;
                hsAct     <= 1'b0;
                vsAct     <= 1'b0;
                evenField <= 1'b0;
            end else if (genTick) begin                                         // [R16]
                genPix    <= next_genPix;
                genLine   <= next_genLine;
                hsAct     <= next_hsAct;
                vsAct     <= next_vsAct;
                evenField <= next_evenField;
            end
        end
    end

    // pin drivers; an edge select of 1 makes the pulse active low
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hsyncOut     <= 1'b0;
            vsyncOut     <= 1'b0;
            hsyncOe      <= 1'b0;
            vsyncOe      <= 1'b0;
            genFieldEven <= 1'b0;
        end else if (ce) begin
            hsyncOe      <= syncGeneratorEnable;                                // [R11]
            vsyncOe      <= syncGeneratorEnable;                                // [R11]
            genFieldEven <= evenField;
            if (!syncGeneratorEnable) begin
                hsyncOut <= hsyncNegativeEdgeSel;
                vsyncOut <= vsyncNegativeEdgeSel;
            end else if (genTick) begin
                hsyncOut <= next_hsAct ^ hsyncNegativeEdgeSel;                  // [R8]
                vsyncOut <= next_vsAct ^ vsyncNegativeEdgeSel;                  // [R9]
            end
        end
    end

endmodule

// File: cfe_capture_front_end_props.sv
`timescale 1ns/1ns

module cfe_capture_front_end_props #(
    parameter int HSYNC_WIDTH = 64
) (
    input wire logic                 clk_sys,
    input wire logic                 rst_n,
    input wire logic                 pixelValid,
    input wire cfe_pkg::cfe_cnt_t    lineCount,
    input wire cfe_pkg::cfe_cnt_t    pixelCount,
    input wire cfe_pkg::cfe_window_s window,
    input wire logic                 syncGeneratorEnable,
    input wire logic                 hsyncNegativeEdgeSel,
    input wire logic                 vsyncNegativeEdgeSel,
    input wire logic                 hsyncOut,
    input wire logic                 hsyncOe,
    input wire logic                 vsyncOut,
    input wire logic                 vsyncOe
);
    import cfe_pkg::*;
    // single domain, so one clocking and one disable serve all
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_valid_gap;
        pixelValid |=> !pixelValid [*8];
    endproperty
    a_valid_gap: assert property (p_valid_gap) else $error("valid pulses too close");
    property p_win_line;
        pixelValid |-> lineCount >= window.firstLineCount && lineCount <= window.lastLineCount;
    endproperty
    a_win_line: assert property (p_win_line) else $error("line outside window");
    property p_win_pix;
        pixelValid |-> pixelCount >= window.firstPixelCount && pixelCount <= window.lastPixelCount;
    endproperty
    a_win_pix: assert property (p_win_pix) else $error("pixel outside window");
    property p_hs_oe;
        $past(rst_n) |-> hsyncOe == $past(syncGeneratorEnable);
    endproperty
    a_hs_oe: assert property (p_hs_oe) else $error("hsync drive wrong");
    property p_vs_oe;
        $past(rst_n) |-> vsyncOe == $past(syncGeneratorEnable);
    endproperty
    a_vs_oe: assert property (p_vs_oe) else $error("vsync drive wrong");
    property p_hs_idle;
        (!syncGeneratorEnable && $stable(hsyncNegativeEdgeSel)) [*3] |-> hsyncOut == hsyncNegativeEdgeSel;
    endproperty
    a_hs_idle: assert property (p_hs_idle) else $error("hsync idle level wrong");
    property p_vs_idle;
        (!syncGeneratorEnable && $stable(vsyncNegativeEdgeSel)) [*3] |-> vsyncOut == vsyncNegativeEdgeSel;
    endproperty
    a_vs_idle: assert property (p_vs_idle) else $error("vsync idle level wrong");
    property p_hs_step;
        syncGeneratorEnable && $changed(hsyncOut) |=> ($stable(hsyncOut) || !syncGeneratorEnable) [*8];
    endproperty
    a_hs_step: assert property (p_hs_step) else $error("hsync moved off tick");
endmodule

bind cfe_capture_front_end cfe_capture_front_end_props #(.HSYNC_WIDTH(HSYNC_WIDTH))
    i_cfe_capture_front_end_props (.clk_sys(clk_sys), .rst_n(rst_n), .pixelValid(pixelValid),
    .lineCount(lineCount), .pixelCount(pixelCount), .window(window),
    .syncGeneratorEnable(syncGeneratorEnable), .hsyncNegativeEdgeSel(hsyncNegativeEdgeSel),
    .vsyncNegativeEdgeSel(vsyncNegativeEdgeSel), .hsyncOut(hsyncOut), .hsyncOe(hsyncOe),
    .vsyncOut(vsyncOut), .vsyncOe(vsyncOe));

// File: cfe_video_source.sv
`timescale 1ns/1ns

// video source: data carries its own pixel and line index for easy checking
module cfe_video_source (
    output logic       dblClk,
    output logic       qualClk,
    output logic [7:0] luma,
    output logic [7:0] chroma,
    output logic       hsync,
    output logic       vsync,
    output logic       field,
    output logic       curField,
    input  wire logic  qualPol,
    input  wire logic  hsNeg,
    input  wire logic  vsNeg
);
    int   p = 0;
    int   l = 0;
    logic bad;
    logic vsAct;
    initial {dblClk, qualClk, luma, chroma, hsync, vsync, field, curField} = '0;
    always #400 dblClk = ~dblClk;
    // odd field puts the vsync edge on a hsync-inactive sample, even on the hsync one
    always @(negedge dblClk) begin
        qualClk <= ~qualClk;
        bad = (~qualClk != qualPol);
        vsAct = curField ? ((l == 0 && p >= 2) || (l == 1 && p < 2)) : (l == 0);
        // unqualified half is inverted, so a wrong edge choice cannot pass
        luma <= {8{bad}} ^ 8'(p);
        chroma <= {8{bad}} ^ 8'(l);
        hsync <= bad ^ (p == 0) ^ hsNeg;
        vsync <= bad ^ vsAct ^ vsNeg;
        field <= bad ^ curField;
        if (bad) begin
            p = (p == 7) ? 0 : p + 1;
            l = (p != 0) ? l : (l == 4) ? 0 : l + 1;
            curField <= curField ^ (p == 0 && l == 0);
        end
    end
endmodule

// File: cfe_capture_front_end_tb.sv
`timescale 1ns/1ns

`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD %0t %h %h", $time, (a), (b)); end end

module cfe_capture_front_end_tb;
    import cfe_pkg::*;
    logic        clk_sys = 0, rst_n = 0, qualPol = 0, extSel = 0, topSel = 0;
    logic        hsNeg = 0, vsNeg = 0, genEn = 0, monOn = 0;
    logic        dbl, qual, srcHs, srcVs, srcField, curField, hsPin, vsPin, expTop;
    logic        pixelValid, fieldTop, hsyncOut, hsyncOe, vsyncOut, vsyncOe, genFieldEven;
    logic [7:0]  srcLuma, srcChroma;
    cfe_pixel_s  pixelOut;
    cfe_cnt_t    lineCount, pixelCount;
    cfe_window_s window = '{10'h001, 10'h003, 10'h002, 10'h005};
    cfe_timing_s timing = '{10'h004, 10'h008, 10'h001, 10'h002};
    int          nTests = 0, mismatches = 0, cyc = 0, validCnt = 0;

    // shared sync pins: the generator wins while it drives
    assign hsPin = hsyncOe ? hsyncOut : srcHs;
    assign vsPin = vsyncOe ? vsyncOut : srcVs;
    assign expTop = extSel ? (curField == topSel) : ((curField ^ ~hsNeg) == topSel);
    always #50 clk_sys = ~clk_sys;

    cfe_video_source i_cfe_video_source (.dblClk(dbl), .qualClk(qual), .luma(srcLuma),
        .chroma(srcChroma), .hsync(srcHs), .vsync(srcVs), .field(srcField),
        .curField(curField), .qualPol(qualPol), .hsNeg(hsNeg), .vsNeg(vsNeg));
    cfe_capture_front_end #(.HSYNC_WIDTH(2)) i_cfe_capture_front_end (.clk_sys(clk_sys),
        .rst_n(rst_n), .ce(1'b1), .doubleRatePixelClock(dbl), .phaseQualifierClock(qual),
        .lumaIn(srcLuma), .chromaIn(srcChroma), .hsyncIn(hsPin), .vsyncIn(vsPin),
        .fieldIdInput(srcField), .qualifierPolaritySel(qualPol), .useExternalFieldSel(extSel),
        .topFieldLevelSel(topSel), .hsyncNegativeEdgeSel(hsNeg), .vsyncNegativeEdgeSel(vsNeg),
        .syncGeneratorEnable(genEn), .window(window), .timing(timing), .pixelOut(pixelOut),
        .pixelValid(pixelValid), .fieldTop(fieldTop), .lineCount(lineCount),
        .pixelCount(pixelCount), .hsyncOut(hsyncOut), .hsyncOe(hsyncOe), .vsyncOut(vsyncOut),
        .vsyncOe(vsyncOe), .genFieldEven(genFieldEven));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // every forwarded sample must carry the index the source put on the bus
    always @(posedge clk_sys) begin
        #1;
        if (monOn && pixelValid === 1'b1) begin
            validCnt++;
            `CHK(pixelOut.luma, pixelCount[7:0])
            `CHK(pixelOut.chroma, lineCount[7:0])
            `CHK(fieldTop, expTop)
        end
    end

    // run is about 20200 cycles, the ceiling leaves ample margin
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            test_done();
        end
    end

    // all qualifier, edge and field settings; 3 lines by 4 pixels per frame in window
    task automatic cap_all;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            {qualPol, hsNeg, vsNeg} = i[2:0];
            extSel = i[1] ^ i[2];
            topSel = i[0] ^ i[2];
            tick(700);
            validCnt = 0;
            monOn = 1;
            tick(1280);
            monOn = 0;
            `CHK(validCnt, 24)
        end
    endtask

    // one tick is 16 cycles: line 8 ticks, hsync at pixel 2, odd vsync pixel 7, even 3
    task automatic gen_run(input logic pol);
        int t, tHs, tVs, c80, c16, nr, k;
        int rise [4];
        logic ph, pv;
        tick(1);
        hsNeg = pol;
        vsNeg = ~pol;
        tick(4);
        `CHK({hsyncOut, vsyncOut, hsyncOe}, {pol, ~pol, 1'b0})
        genEn = 1;
        tick(1100);
        `CHK(vsyncOe, 1'b1)
        pv = vsyncOut;
        for (k = 0; k < 600 && vsyncOut === pv; k++) tick(1);
        {tHs, tVs, c80, c16, nr} = '0;
        rise = '{default: 0};
        ph = hsyncOut;
        pv = vsyncOut;
        for (t = 1; t <= 1024; t++) begin
            tick(1);
            if (hsyncOut !== ph && hsyncOut === ~pol) begin
                if (tHs > 0) `CHK(t - tHs, 128)
                tHs = t;
            end
            if (vsyncOut !== pv) begin
                c80 += (t - tHs == 80);
                c16 += (t - tHs == 16);
                if (vsyncOut === pol) begin
                    if (nr < 4) rise[nr] = t;
                    nr++;
                    tVs = t;
                end else if (tVs > 0) begin
                    `CHK(t - tVs, 128)
                    // the field flag lags a cycle, so it is settled by the pulse end
                    `CHK(genFieldEven, (t - tHs == 16))
                end
            end
            ph = hsyncOut;
            pv = vsyncOut;
        end
        `CHK(c80, 4)
        `CHK(c16, 4)
        `CHK(rise[2] - rise[0], 512)
        genEn = 0;
    endtask

    initial begin
        tick(10);
        rst_n = 1;
        cap_all();
        gen_run(1'b0);
        gen_run(1'b1);
        test_done();
    end
endmodule
